// ---- src/nvmpe_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvmpe_ctrl
    import nvmpe_pkg::*;
#(
    parameter logic [15:0] VERSION_ID = 16'h0001, // arbitrary value
    parameter int PF_AWP = PF_AW,
    parameter int EE_AWP = EE_AW
) (
    input wire logic core_clk, // system clock, 25 MHz
    input wire logic rst, // synchronous reset, active high
    input wire nvmpe_cmd_wr_t cmd_wr, // command object word write
    input wire logic cmd_launch, // start the loaded command
    input wire nvmpe_rd_req_t rd_req, // array read request
    input wire logic secured, // device secured level
    input wire logic pprot_en, // program store high region protect
    input wire logic [BA_W-1:0] pprot_base, // first protected store byte
    input wire logic eprot_en, // eeprom high region protect
    input wire logic [BA_W-1:0] eprot_base, // first protected eeprom byte
    input wire logic done_irq_en, // completion interrupt enable
    input wire logic err_irq_en, // error interrupt enable
    input wire logic done_irq_ack, // acknowledge completion interrupt
    input wire nvmpe_flags_t flag_clr, // one-cycle clear of sticky flags
    output nvmpe_rd_rsp_t rd_rsp, // read answer
    output logic command_complete_flag, // high when idle
    output nvmpe_flags_t flags, // sticky status flags
    output logic done_irq, // completion interrupt
    output logic err_irq // error interrupt
);
    typedef enum logic [1:0] {S_IDLE, S_WRITE, S_RDBACK, S_CMP} nvmpe_state_t;

    nvmpe_state_t state_reg;
    logic [15:0] obj_reg [0:OBJ_WORDS-1];
    nvmpe_space_t tgt_reg;
    logic ers_reg;
    logic [PF_AW-1:0] ptr_reg;
    logic [7:0] left_reg;
    logic [1:0] widx_reg;
    logic vfail_reg;
    logic [15:0] once_reg [0:ONCE_WORDS-1];
    logic [ONCE_PHRASES-1:0] once_used_reg;
    logic [PF_CW_W-1:0] pf_rdata;
    logic [EE_CW_W-1:0] ee_rdata;
    nvmpe_rd_req_t r1_reg;
    logic r1_err_reg;
    logic [15:0] info_q_reg;
    nvmpe_flags_t set_flags;
    logic cmd_done_pulse;
    logic err_pend_reg;

    // launch decode from the command object
    logic [7:0] code;
    logic [BA_W-1:0] baddr;
    logic [1:0] ecnt;
    logic go;
    logic bad_align;
    logic bad_prot;
    logic bad_code;
    logic pf_busy;
    logic ee_busy;
    assign code = obj_reg[OBJ_CODE][CODE_HI:CODE_LO];
    assign baddr = {obj_reg[OBJ_CODE][ADDR16_BIT], obj_reg[OBJ_ADDR]};
    assign ecnt = obj_reg[OBJ_CODE][CNT_HI:CNT_LO];
    assign go = cmd_launch && command_complete_flag;
    assign pf_busy = (state_reg != S_IDLE) && (tgt_reg == NVMPE_SP_PF);
    assign ee_busy = (state_reg != S_IDLE) && (tgt_reg == NVMPE_SP_EE);

    // alignment, range and protection checks before anything is written
    always_comb
    begin
        bad_align = 1'b0;
        bad_prot = 1'b0;
        bad_code = 1'b0;
        unique case (code)
            CMD_PGM_PF:
            begin
                bad_align = (baddr[2:0] != 3'h0);
                bad_prot = pprot_en && (baddr >= pprot_base);
            end
            CMD_ERS_PSEC:
            begin
                bad_prot = pprot_en && ({baddr[BA_W-1:9], 9'h000} >= pprot_base);
            end
            CMD_PGM_EE:
            begin
                bad_align = (baddr[0] != 1'b0) || (baddr[BA_W-1:12] != '0);
                bad_prot = eprot_en && (baddr >= eprot_base);
            end
            CMD_ERS_ESEC:
            begin
                bad_align = (baddr[BA_W-1:12] != '0);
                bad_prot = eprot_en && ({baddr[BA_W-1:2], 2'h0} >= eprot_base);
            end
            CMD_PGM_ONCE:
            begin
                bad_align = (baddr >= BA_W'(ONCE_PHRASES));
                bad_prot = !bad_align && once_used_reg[baddr[2:0]];
            end
            default:
            begin
                bad_code = 1'b1;
            end
        endcase
    end

    // command object: writes only land while idle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < OBJ_WORDS; i++)
            begin
                obj_reg[i] <= '0;
            end
        end
        else if (cmd_wr.valid && command_complete_flag && (cmd_wr.idx <= OBJ_MAX_IDX))
        begin
            obj_reg[cmd_wr.idx] <= cmd_wr.data;
        end
    end

    // expected codeword of the current step, ecc made here not by the host
    logic [DW_W-1:0] wr_dw;
    logic [PF_CW_W-1:0] pf_exp;
    logic [EE_CW_W-1:0] ee_exp;
    assign wr_dw = (tgt_reg == NVMPE_SP_PF) ?
        {obj_reg[OBJ_DATA + 1 + 2 * widx_reg[0]], obj_reg[OBJ_DATA + 2 * widx_reg[0]]} :
        {16'h0000, obj_reg[OBJ_DATA + widx_reg]};
    assign pf_exp = ers_reg ? '1 : {nvmpe_ecc_gen(wr_dw), wr_dw};
    assign ee_exp = ers_reg ? '1 : {nvmpe_ecc_gen(wr_dw), wr_dw[EW_W-1:0]};

    // sequencer: write, read back, compare, step to next unit
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg <= S_IDLE;
            tgt_reg <= NVMPE_SP_PF;
            ers_reg <= 1'b0;
            ptr_reg <= '0;
            left_reg <= '0;
            widx_reg <= '0;
            vfail_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                S_IDLE:
                begin
                    vfail_reg <= 1'b0;
                    widx_reg <= '0;
                    if (go && !secured && !bad_align && !bad_prot && !bad_code
                        && (code != CMD_PGM_ONCE))
                    begin
                        state_reg <= S_WRITE;
                        ers_reg <= (code == CMD_ERS_PSEC) || (code == CMD_ERS_ESEC);
                        if ((code == CMD_PGM_PF) || (code == CMD_ERS_PSEC))
                        begin
                            tgt_reg <= NVMPE_SP_PF;
                            if (code == CMD_PGM_PF)
                            begin
                                ptr_reg <= baddr[BA_W-1:2];
                                left_reg <= PF_PHRASE_DW - 8'h01;
                            end
                            else
                            begin
                                ptr_reg <= {baddr[BA_W-1:9], 7'h00};
                                left_reg <= PF_SECTOR_DW - 8'h01;
                            end
                        end
                        else
                        begin
                            tgt_reg <= NVMPE_SP_EE;
                            if (code == CMD_PGM_EE)
                            begin
                                ptr_reg <= {4'h0, baddr[11:1]};
                                left_reg <= {6'h00, ecnt};
                            end
                            else
                            begin
                                ptr_reg <= {4'h0, baddr[11:2], 1'b0};
                                left_reg <= EE_SECTOR_WD - 8'h01;
                            end
                        end
                    end
                end
                S_WRITE:
                begin
                    state_reg <= S_RDBACK;
                end
                S_RDBACK:
                begin
                    state_reg <= S_CMP;
                end
                S_CMP:
                begin
                    // verify the cell contents against what was meant
                    if ((tgt_reg == NVMPE_SP_PF) ? (pf_rdata != pf_exp) : (ee_rdata != ee_exp))
                    begin
                        vfail_reg <= 1'b1;
                    end
                    if (left_reg == 8'h00)
                    begin
                        state_reg <= S_IDLE;
                    end
                    else
                    begin
                        state_reg <= S_WRITE;
                        left_reg <= left_reg - 8'h01;
                        ptr_reg <= ptr_reg + 1'b1;
                        widx_reg <= widx_reg + 2'h1;
                    end
                end
            endcase
        end
    end

    // complete flag low from launch until the last compare
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            command_complete_flag <= 1'b1;
        end
        else if (go && !secured && !bad_align && !bad_prot && !bad_code
                 && (code != CMD_PGM_ONCE))
        begin
            command_complete_flag <= 1'b0;
        end
        else if ((state_reg == S_CMP) && (left_reg == 8'h00))
        begin
            command_complete_flag <= 1'b1;
        end
    end
    assign cmd_done_pulse = (go && (secured || bad_align || bad_prot || bad_code
                                    || (code == CMD_PGM_ONCE)))
                            || ((state_reg == S_CMP) && (left_reg == 8'h00));

    // program-once field: a phrase can be written a single time until reset clears once_used_reg
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            once_used_reg <= '0;
        end
        else if (go && (code == CMD_PGM_ONCE) && !secured && !bad_align && !bad_prot)
        begin
            once_used_reg[baddr[2:0]] <= 1'b1;
        end
    end
    // the once contents survive reset, they model nonvolatile cells
    always_ff @(posedge core_clk)
    begin
        if (go && (code == CMD_PGM_ONCE) && !secured && !bad_align && !bad_prot)
        begin
            for (int i = 0; i < 4; i++)
            begin
                once_reg[{baddr[2:0], 2'(i)}] <= obj_reg[OBJ_DATA + i];
            end
        end
    end

    // arrays, each on its own port so store reads run during eeprom work
    logic pf_seq;
    logic ee_seq;
    logic rd_ok;
    assign pf_seq = pf_busy && ((state_reg == S_WRITE) || (state_reg == S_RDBACK));
    assign ee_seq = ee_busy && ((state_reg == S_WRITE) || (state_reg == S_RDBACK));
    assign rd_ok = rd_req.valid && !secured;

    nvmpe_mem #(.AW(PF_AWP), .DW(PF_CW_W)) u_pf_mem (
        .core_clk(core_clk),
        .we(pf_busy && (state_reg == S_WRITE)),
        .re(pf_seq || (rd_ok && !pf_busy && (rd_req.space == NVMPE_SP_PF))),
        .addr(pf_seq ? ptr_reg[PF_AWP-1:0] : rd_req.addr[PF_AWP+1:2]),
        .wdata(pf_exp),
        .rdata(pf_rdata)
    );

    nvmpe_mem #(.AW(EE_AWP), .DW(EE_CW_W)) u_ee_mem (
        .core_clk(core_clk),
        .we(ee_busy && (state_reg == S_WRITE)),
        .re(ee_seq || (rd_ok && !ee_busy && !pf_busy && (rd_req.space == NVMPE_SP_EE))),
        .addr(ee_seq ? ptr_reg[EE_AWP-1:0] : rd_req.addr[EE_AWP:1]),
        .wdata(ee_exp),
        .rdata(ee_rdata)
    );

    // read stage one: accept or refuse, fetch info words
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            r1_reg <= '0;
            r1_err_reg <= 1'b0;
            info_q_reg <= '1;
        end
        else
        begin
            r1_reg <= rd_req;
            r1_err_reg <= secured
                || ((rd_req.space == NVMPE_SP_EE) && (pf_busy || ee_busy))
                || ((rd_req.space == NVMPE_SP_PF) && pf_busy);
            if (rd_req.addr[7:1] == INFO_VER_OFS[7:1])
            begin
                info_q_reg <= VERSION_ID;
            end
            else if (rd_req.addr[7:0] >= INFO_ONCE_OFS)
            begin
                info_q_reg <= once_used_reg[rd_req.addr[5:3]] ?
                    once_reg[rd_req.addr[5:1]] : 16'hFFFF;
            end
            else
            begin
                info_q_reg <= 16'hFFFF;
            end
        end
    end

    // read stage two: ecc on the fetched unit, then lane select
    nvmpe_ecc_res_t fix;
    logic erased;
    logic [15:0] half;
    always_comb
    begin
        if (r1_reg.space == NVMPE_SP_PF)
        begin
            erased = (pf_rdata == '1);
            fix = nvmpe_ecc_fix(pf_rdata[DW_W-1:0], pf_rdata[PF_CW_W-1:DW_W]);
            half = r1_reg.addr[1] ? fix.data[31:16] : fix.data[15:0];
        end
        else if (r1_reg.space == NVMPE_SP_EE)
        begin
            erased = (ee_rdata == '1);
            fix = nvmpe_ecc_fix({16'h0000, ee_rdata[EW_W-1:0]}, ee_rdata[EE_CW_W-1:EW_W]);
            half = fix.data[15:0];
        end
        else
        begin
            erased = 1'b1;
            fix = '0;
            half = info_q_reg;
        end
        if (erased)
        begin
            fix.sgl = 1'b0;
            fix.dbl = 1'b0;
            if (r1_reg.space != NVMPE_SP_INFO)
            begin
                half = 16'hFFFF;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rd_rsp <= '0;
        end
        else
        begin
            rd_rsp.valid <= r1_reg.valid;
            rd_rsp.err <= r1_reg.valid && (r1_err_reg || fix.dbl);
            rd_rsp.corrected <= r1_reg.valid && !r1_err_reg && fix.sgl;
            if (!r1_reg.valid || r1_err_reg)
            begin
                rd_rsp.data <= '0;
            end
            else if (r1_reg.word)
            begin
                rd_rsp.data <= half;
            end
            else
            begin
                rd_rsp.data <= {8'h00, r1_reg.addr[0] ? half[15:8] : half[7:0]};
            end
        end
    end

    // sticky flags, a set in the clear cycle wins
    always_comb
    begin
        set_flags.acc_err = go && (secured || bad_align || bad_code);
        set_flags.prot_viol = go && !secured && !bad_align && !bad_code && bad_prot;
        set_flags.verify_err = (state_reg == S_CMP) && (left_reg == 8'h00) && (vfail_reg
            || ((tgt_reg == NVMPE_SP_PF) ? (pf_rdata != pf_exp) : (ee_rdata != ee_exp)));
        set_flags.sgl_fault = r1_reg.valid && !r1_err_reg && fix.sgl;
        set_flags.dbl_fault = r1_reg.valid && !r1_err_reg && fix.dbl;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            flags <= '0;
        end
        else
        begin
            flags <= (flags & ~flag_clr) | set_flags;
        end
    end

    // interrupts: completion latched until acked, error follows the double fault flag
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            done_irq <= 1'b0;
            err_irq <= 1'b0;
            err_pend_reg <= 1'b0;
        end
        else
        begin
            done_irq <= done_irq_en && (cmd_done_pulse || (done_irq && !done_irq_ack));
            err_pend_reg <= set_flags.dbl_fault || (flags.dbl_fault && !flag_clr.dbl_fault);
            err_irq <= err_irq_en && err_pend_reg;
        end
    end
endmodule // nvmpe_ctrl
`default_nettype wire

// ---- src/nvmpe_pkg.sv ----
package nvmpe_pkg;

    // array geometry
    localparam int PF_BYTES = 131072;
    localparam int PF_SECTOR_BYTES = 512;
    localparam int EE_BYTES = 4096;
    localparam int EE_SECTOR_BYTES = 4;
    localparam int DW_W = 32;
    localparam int EW_W = 16;
    localparam int ECC_W = 7;
    localparam int PF_CW_W = DW_W + ECC_W;
    localparam int EE_CW_W = EW_W + ECC_W;
    localparam int PF_AW = 15;
    localparam int EE_AW = 11;
    localparam int BA_W = 17;
    localparam logic [7:0] PF_SECTOR_DW = 8'(PF_SECTOR_BYTES / 4);
    localparam logic [7:0] EE_SECTOR_WD = 8'(EE_SECTOR_BYTES / 2);
    localparam logic [7:0] PF_PHRASE_DW = 8'h02;

    // command object layout
    localparam int OBJ_WORDS = 6;
    localparam logic [2:0] OBJ_MAX_IDX = 3'h5;
    localparam int OBJ_CODE = 0;
    localparam int OBJ_ADDR = 1;
    localparam int OBJ_DATA = 2;
    localparam int CODE_HI = 15;
    localparam int CODE_LO = 8;
    localparam int CNT_HI = 2;
    localparam int CNT_LO = 1;
    localparam int ADDR16_BIT = 0;

    // command codes
    localparam logic [7:0] CMD_PGM_PF = 8'h06;
    localparam logic [7:0] CMD_PGM_ONCE = 8'h07;
    localparam logic [7:0] CMD_ERS_PSEC = 8'h0A;
    localparam logic [7:0] CMD_PGM_EE = 8'h11;
    localparam logic [7:0] CMD_ERS_ESEC = 8'h12;

    // info region layout
    localparam logic [7:0] INFO_VER_OFS = 8'hB6;
    localparam logic [7:0] INFO_ONCE_OFS = 8'hC0;
    localparam int ONCE_PHRASES = 8;
    localparam int ONCE_WORDS = 32;

    typedef enum logic [1:0] {NVMPE_SP_PF, NVMPE_SP_EE, NVMPE_SP_INFO} nvmpe_space_t;

    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic [15:0] data;
    } nvmpe_cmd_wr_t;

    typedef struct packed {
        logic valid;
        nvmpe_space_t space;
        logic word;
        logic [BA_W-1:0] addr;
    } nvmpe_rd_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic corrected;
        logic [15:0] data;
    } nvmpe_rd_rsp_t;

    // sticky flags, the clear input uses the same layout
    typedef struct packed {
        logic acc_err;
        logic prot_viol;
        logic verify_err;
        logic sgl_fault;
        logic dbl_fault;
    } nvmpe_flags_t;

    typedef struct packed {
        logic sgl;
        logic dbl;
        logic [DW_W-1:0] data;
    } nvmpe_ecc_res_t;

    // hamming check bits over positions 1..38, bit 6 is overall parity
    function automatic logic [ECC_W-1:0] nvmpe_ecc_gen(input logic [DW_W-1:0] d);
        logic [ECC_W-1:0] c;
        int k;
        c = '0;
        k = 0;
        for (int p = 1; p < PF_CW_W; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                for (int j = 0; j < ECC_W - 1; j++)
                begin
                    if (p[j])
                    begin
                        c[j] = c[j] ^ d[k];
                    end
                end
                k++;
            end
        end
        c[ECC_W-1] = (^d) ^ (^c[ECC_W-2:0]);
        return c;
    endfunction

    // single fault corrected, double fault only detected
    function automatic nvmpe_ecc_res_t nvmpe_ecc_fix(input logic [DW_W-1:0] d,
                                                     input logic [ECC_W-1:0] c);
        nvmpe_ecc_res_t r;
        logic [ECC_W-2:0] syn;
        logic pe;
        logic [ECC_W-1:0] g;
        int k;
        g = nvmpe_ecc_gen(d);
        syn = g[ECC_W-2:0] ^ c[ECC_W-2:0];
        pe = ^{d, c};
        r.data = d;
        r.sgl = pe;
        r.dbl = !pe && (syn != '0);
        k = 0;
        for (int p = 1; p < PF_CW_W; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                if (pe && (6'(p) == syn))
                begin
                    r.data[k] = !d[k];
                end
                k++;
            end
        end
        return r;
    endfunction

endpackage

// ---- src/nvmpe_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvmpe_mem #(
    parameter int AW = 11,
    parameter int DW = 23
) (
    input wire logic core_clk, // system clock
    input wire logic we, // write strobe
    input wire logic re, // read strobe
    input wire logic [AW-1:0] addr, // word address
    input wire logic [DW-1:0] wdata, // codeword to store
    output logic [DW-1:0] rdata // registered codeword
);
    // nonvolatile array starts in the erased state, set at declaration so only one process writes it
    logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: '1};

    // one port: a write takes the cycle, a read returns next cycle
    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        else if (re)
        begin
            rdata <= mem[addr];
        end
    end
endmodule // nvmpe_mem
`default_nettype wire

// ---- tb/nvmpe_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvmpe_assertions
    import nvmpe_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst, // sync reset
    input wire logic cmd_launch, // launch pulse
    input wire nvmpe_rd_req_t rd_req, // read request
    input wire logic secured, // secured level
    input wire logic done_irq_en, // irq enable
    input wire nvmpe_flags_t flag_clr, // flag clears
    input wire nvmpe_rd_rsp_t rd_rsp, // read answer
    input wire logic command_complete_flag, // idle
    input wire nvmpe_flags_t flags, // sticky flags
    input wire logic done_irq // completion irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // request and its answer two edges on
    sequence s_req;
        rd_req.valid;
    endsequence
    sequence s_ans;
        ##2 rd_rsp.valid;
    endsequence
    a_read_latency: assert property (s_req |-> s_ans)
        else $error("read answer late");
    a_rsp_cause: assert property (rd_rsp.valid |-> $past(rd_req.valid, 2))
        else $error("answer without request");
    a_secure_refuse: assert property (s_req and secured |-> ##2 rd_rsp.err && rd_rsp.data == 0)
        else $error("secured read served");
    a_ee_blocked: assert property (s_req and rd_req.space == NVMPE_SP_EE && !command_complete_flag
        |-> ##2 rd_rsp.err)
        else $error("eeprom read during command");
    // erase of a store sector is the longest run, 384 cycles, just inside the bound of 400
    a_busy_bound: assert property ($fell(command_complete_flag) |-> ##[1:400] command_complete_flag)
        else $error("command never completes");
    a_fall_cause: assert property ($fell(command_complete_flag) |-> $past(cmd_launch))
        else $error("busy without launch");
    a_acc_sticky: assert property (flags.acc_err && !flag_clr.acc_err |=> flags.acc_err)
        else $error("access flag lost");
    a_done_irq: assert property ($rose(command_complete_flag) && done_irq_en |-> ##[0:1] done_irq)
        else $error("no completion irq");
endmodule // nvmpe_assertions
bind nvmpe_ctrl nvmpe_assertions i_chk (.core_clk, .rst, .cmd_launch, .rd_req, .secured,
    .done_irq_en, .flag_clr, .rd_rsp, .command_complete_flag, .flags, .done_irq);
`default_nettype wire

// ---- tb/nvmpe_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvmpe_host
    import nvmpe_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic idle, // complete flag
    input wire nvmpe_rd_rsp_t rsp, // read answer
    output nvmpe_cmd_wr_t cmd_wr, // object write
    output logic cmd_launch, // launch pulse
    output nvmpe_rd_req_t rd_req // read request
);
    // quiet bus from time zero
    initial
    begin
        cmd_wr = '0;
        cmd_launch = 1'b0;
        rd_req = '0;
    end
    // load all six words, launch, then hold off until idle again
    task automatic cmd(input logic [7:0] c, input logic [1:0] n, input logic [16:0] a,
                       input logic [63:0] d);
        logic [15:0] w[6];
        w = '{{c, 5'h00, n, a[16]}, a[15:0], d[15:0], d[31:16], d[47:32], d[63:48]};
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            cmd_wr <= '{1'b1, 3'(i), w[i]};
        end
        @(posedge core_clk);
        cmd_wr <= '0;
        cmd_launch <= 1'b1;
        @(posedge core_clk);
        cmd_launch <= 1'b0;
        repeat (2) @(posedge core_clk);
        // a hang is left to the bench watchdog, which fails the run
        while (!idle)
            @(posedge core_clk);
    endtask
    // released address is inverted so a stale value never looks valid
    task automatic rd(input nvmpe_space_t s, input logic wd, input logic [16:0] a,
                      output nvmpe_rd_rsp_t r);
        @(posedge core_clk);
        rd_req <= '{1'b1, s, wd, a};
        @(posedge core_clk);
        rd_req <= '{1'b0, s, wd, ~a};
        // the answer stands only in the cycle after the edge that follows the accepting edge
        @(posedge core_clk);
        #1 r = rsp;
    endtask
endmodule // nvmpe_host
`default_nettype wire

// ---- tb/nvm_program_erase_controller_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvm_program_erase_controller_test
    import nvmpe_pkg::*;
;
    localparam logic [15:0] VER = 16'h5A3C; // arbitrary value
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic secured = 1'b0;
    logic pprot_en = 1'b0;
    logic [BA_W-1:0] pprot_base = 17'h10000;
    logic done_irq_en = 1'b1;
    logic done_irq_ack = 1'b0;
    nvmpe_cmd_wr_t cmd_wr;
    logic cmd_launch;
    nvmpe_rd_req_t rd_req;
    nvmpe_rd_rsp_t rd_rsp;
    nvmpe_rd_rsp_t r;
    logic idle;
    nvmpe_flags_t flags;
    logic done_irq;
    logic [31:0] seed = 32'h7412;
    logic [63:0] d;
    int errors = 0;
    int compares = 0;
    // 25 MHz
    always #20 core_clk = ~core_clk;
    nvmpe_ctrl #(.VERSION_ID(VER)) i_dut (.core_clk(core_clk), .rst(rst), .cmd_wr(cmd_wr),
        .cmd_launch(cmd_launch), .rd_req(rd_req), .secured(secured), .pprot_en(pprot_en),
        .pprot_base(pprot_base), .eprot_en(1'b0), .eprot_base('0), .done_irq_en(done_irq_en),
        .err_irq_en(1'b1), .done_irq_ack(done_irq_ack), .flag_clr('0), .rd_rsp(rd_rsp),
        .command_complete_flag(idle), .flags(flags), .done_irq(done_irq), .err_irq());
    nvmpe_host i_host (.core_clk(core_clk), .idle(idle), .rsp(rd_rsp), .cmd_wr(cmd_wr),
        .cmd_launch(cmd_launch), .rd_req(rd_req));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // word of a phrase or burst that a byte address selects
    function automatic logic [15:0] word_of(input logic [63:0] v, input logic [16:0] a);
        return v[16 * a[2:1] +: 16];
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard, far beyond the longest sequence
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        wrap_up();
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        i_host.rd(NVMPE_SP_PF, 1'b1, 17'h00100, r);
        chk("erased", 16'hFFFF, r.data);
        d = {xs(), xs()};
        i_host.cmd(CMD_PGM_PF, 2'h0, 17'h00100, d);
        chk("done_irq", 16'h0001, 16'(done_irq));
        // acknowledge so that later completions raise the interrupt afresh
        done_irq_ack <= 1'b1;
        @(posedge core_clk);
        done_irq_ack <= 1'b0;
        @(posedge core_clk);
        #1 chk("irq_ack", 16'h0000, 16'(done_irq));
        for (int i = 0; i < 8; i += 2)
        begin
            i_host.rd(NVMPE_SP_PF, 1'b1, 17'(256 + i), r);
            chk("phrase", word_of(d, 17'(i)), r.data);
        end
        i_host.rd(NVMPE_SP_PF, 1'b0, 17'h00103, r);
        chk("byte", 16'(d[31:24]), 16'(r.data[7:0]));
        // misaligned and protected targets must leave the array erased
        i_host.cmd(CMD_PGM_PF, 2'h0, 17'h00204, d);
        chk("acc_err", 16'h0001, 16'(flags.acc_err));
        pprot_en <= 1'b1;
        i_host.cmd(CMD_PGM_PF, 2'h0, 17'h10000, d);
        chk("prot_viol", 16'h0001, 16'(flags.prot_viol));
        pprot_en <= 1'b0;
        i_host.rd(NVMPE_SP_PF, 1'b1, 17'h10000, r);
        chk("protected", 16'hFFFF, r.data);
        i_host.rd(NVMPE_SP_PF, 1'b1, 17'h00204, r);
        chk("misaligned", 16'hFFFF, r.data);
        // store read lands mid-way through the eeprom burst
        fork
            i_host.cmd(CMD_PGM_EE, 2'h1, 17'h00010, d);
            begin
                repeat (8) @(posedge core_clk);
                i_host.rd(NVMPE_SP_PF, 1'b1, 17'h00104, r);
                chk("pf_during_ee", word_of(d, 17'h00004), r.data);
            end
        join
        for (int i = 0; i < 4; i += 2)
        begin
            i_host.rd(NVMPE_SP_EE, 1'b1, 17'(16 + i), r);
            chk("ee_burst", word_of(d, 17'(i)), r.data);
        end
        fork
            i_host.cmd(CMD_ERS_PSEC, 2'h0, 17'h00100, '1);
            begin
                repeat (30) @(posedge core_clk);
                i_host.rd(NVMPE_SP_EE, 1'b1, 17'h00010, r);
                chk("ee_busy", 16'h0001, 16'(r.err));
            end
        join
        i_host.rd(NVMPE_SP_PF, 1'b1, 17'h00102, r);
        chk("sector_erased", 16'hFFFF, r.data);
        i_host.rd(NVMPE_SP_INFO, 1'b1, 17'h000B6, r);
        chk("version", VER, r.data);
        secured <= 1'b1;
        i_host.rd(NVMPE_SP_EE, 1'b1, 17'h00010, r);
        chk("secured", 16'h0001, 16'(r.err));
        wrap_up();
    end
endmodule // nvm_program_erase_controller_test
`default_nettype wire
